// >>> core/arith_pkg.sv
// Shared constants for the divide-step and selective-clear datapath.
// Assumes a 100 MHz clock; times are held in ns and turned into cycles.
package arith_pkg;

    // ========================================================================
    // Word format
    localparam int WORD_W = 24;
    localparam int ADDR_W = 15;
    localparam int SIGN_BIT = 23;

    // ========================================================================
    // Operation codes (octal as printed)
    localparam logic [5:0] OP_DIVIDE_STEP = 6'o61;
    localparam logic [5:0] OP_SEL_CLEAR = 6'o62;

    // ========================================================================
    // Instruction fields
    localparam int OP_LSB = 18;
    localparam int IDX_LSB = 15;
    localparam int MOD_LSB = 21;

    // ========================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIV_TIME_NS = 64_000;
    localparam int DIV_REPEAT_TIME_NS = 44_000;
    localparam int DIV_CYCLES = DIV_TIME_NS / CLK_PERIOD_NS;
    localparam int DIV_REPEAT_CYCLES = DIV_REPEAT_TIME_NS / CLK_PERIOD_NS;

    // ========================================================================
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_EXEC  = 4'b1000
    } seq_state_t;

endpackage

// >>> core/divide_step_selective_clear.sv
// Arithmetic datapath executing the divide step and the selective clear.
// Assumes a sequencer issues one instruction per start pulse and a core
// storage port answers a read some cycles later with rd_valid.
//
// Overview of operation
// RL1: Divide step shifts accumulator and extension left
// RL2: Then subtract fetched operand from accumulator
// RL3: Sign clear: set low quotient bit, keep difference
// RL4: Sign set: clear quotient bit, add operand back
// RL5: Program clears accumulator, loads dividend, steps 24
// RL6: Quotient ends in extension, remainder in accumulator
// RL7: Long division needs divisor above high half
// RL8: Only positive dividend and divisor are supported
// RL9: Step takes 64 us, repeat 44 us
// RL10: Modifier and index applied; repeat supported
// RL11: Selective clear zeroes accumulator bits where operand ones
// RL12: Shift drops accumulator top, zero into quotient
`timescale 1ns/10ps
module divide_step_selective_clear #(
    parameter int STEP_CYCLES   = arith_pkg::DIV_CYCLES,
    parameter int REPEAT_CYCLES = arith_pkg::DIV_REPEAT_CYCLES
) (
    // Clock, reset and enable
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Instruction from the sequencer
    input  wire logic        start,
    input  wire logic [23:0] instr,
    input  wire logic [5:0]  repeat_count,
    input  wire logic [14:0] index_value,
    // Program setup preload
    input  wire logic        load_en,
    input  wire logic [23:0] load_acc,
    input  wire logic [23:0] load_ext,
    // Core storage read port
    output logic             rd_req,
    output logic      [14:0] rd_addr,
    input  wire logic        rd_valid,
    input  wire logic [23:0] rd_data,
    // Status and results
    output logic             busy,
    output logic             done,
    output logic      [23:0] acc,
    output logic      [23:0] ext
);
    localparam int W  = arith_pkg::WORD_W;
    // Wide enough for the longest step count at the default clock
    localparam int CW = 16;

    // ========================================================================
    // Opcode decode, shared by the step logic and the repeat logic
    function automatic logic is_divide(input logic [5:0] op);
        return op == arith_pkg::OP_DIVIDE_STEP;
    endfunction

    function automatic logic is_clear(input logic [5:0] op);
        return op == arith_pkg::OP_SEL_CLEAR;
    endfunction

    // ========================================================================
    // Sequencer state
    arith_pkg::seq_state_t state_q;
    arith_pkg::seq_state_t state_d;
    logic [CW-1:0]  cnt_q;
    logic [CW-1:0]  cnt_d;
    logic [5:0]     rep_q;
    logic [5:0]     rep_d;
    logic           first_q;
    logic           first_d;
    logic           done_q;
    logic           done_d;

    // Latched instruction fields
    logic [14:0]    addr_q;
    logic [14:0]    addr_d;
    logic [5:0]     op_q;
    logic [5:0]     op_d;
    logic [2:0]     mod_q;
    logic [2:0]     mod_d;

    // Arithmetic registers and the fetched operand
    logic [W-1:0]   acc_q;
    logic [W-1:0]   acc_d;
    logic [W-1:0]   ext_q;
    logic [W-1:0]   ext_d;
    logic [W-1:0]   opnd_q;
    logic [W-1:0]   opnd_d;

    // Combinational step values
    logic [W-1:0]   portion;
    logic [2*W-1:0] shifted;
    logic [W-1:0]   diff;

    // ========================================================================
    // Operand portion selection
    portion_select #(
        .WIDTH (W)
    ) u_portion (
        .modifier (mod_q),
        .word_in  (rd_data),
        .word_out (portion)                     // [RL10]
    );

    // Shift left as one open-ended pair; top bit falls off
    // Bit 23 of the accumulator is lost, never carried anywhere
    assign shifted = {acc_q[W-2:0], ext_q, 1'b0};         // [RL1] [RL12]
    assign diff = shifted[2*W-1:W] - opnd_q;              // [RL2]

    // ========================================================================
    // Sequencer and datapath next state
    always_comb begin
        state_d = state_q;
        acc_d   = acc_q;
        ext_d   = ext_q;
        opnd_d  = opnd_q;
        addr_d  = addr_q;
        op_d    = op_q;
        mod_d   = mod_q;
        rep_d   = rep_q;
        first_d = first_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        unique case (state_q)
            arith_pkg::ST_IDLE: begin
                // Program setup preload is honoured only while idle
                if (load_en) begin
                    acc_d = load_acc;
                    ext_d = load_ext;
                end
                if (start) begin
                    op_d    = instr[23:arith_pkg::OP_LSB];
                    mod_d   = instr[arith_pkg::MOD_LSB-1 -: 3];
                    // Index designator added to address   [RL10]
                    addr_d  = instr[arith_pkg::ADDR_W-1:0] + index_value;
                    rep_d   = repeat_count;
                    first_d = 1'b1;
                    state_d = arith_pkg::ST_FETCH;
                end
            end
            arith_pkg::ST_FETCH: begin
                // One cycle of read request; storage answers during WAIT
                state_d = arith_pkg::ST_WAIT;
            end
            arith_pkg::ST_WAIT: begin
                if (rd_valid) begin
                    opnd_d  = portion;
                    // Loaded short so the result lands on the last cycle
                    cnt_d   = CW'(first_q ? STEP_CYCLES - 2 : REPEAT_CYCLES - 2);
                    state_d = arith_pkg::ST_EXEC;
                end
            end
            arith_pkg::ST_EXEC: begin
                // Hold the step so each costs its machine time   [RL9]
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    // Positive operands only: the sign test reads bit 23
                    // of the difference, so a divisor with its top bit set
                    // or one not above the high half gives a wrong quotient
                    if (is_divide(op_q)) begin
                        if (diff[arith_pkg::SIGN_BIT] == 1'b0) begin
                            acc_d = diff;                         // [RL3]
                            ext_d = {shifted[W-1:1], 1'b1};       // [RL3]
                        end else begin
                            acc_d = diff + opnd_q;                // [RL4]
                            ext_d = shifted[W-1:0];               // [RL4]
                        end
                    end else if (is_clear(op_q)) begin
                        acc_d = acc_q & ~opnd_q;                  // [RL11]
                    end
                    // Any other opcode finishes without touching registers
                    first_d = 1'b0;
                    // Repeat reuses the fetched operand   [RL10] [RL6]
                    // Storage is read once per instruction, so a repeated
                    // step costs only the shorter repeat time
                    if (rep_q != '0 && is_divide(op_q)) begin
                        rep_d = rep_q - 1'b1;
                        cnt_d = CW'(REPEAT_CYCLES - 1);
                    end else begin
                        done_d  = 1'b1;
                        state_d = arith_pkg::ST_IDLE;
                    end
                end
            end
            default: state_d = arith_pkg::ST_IDLE;
        endcase
    end

    // ========================================================================
    // Registers; clock enable freezes everything
    // A frozen cycle also holds done, so a pulse can outlast one clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= arith_pkg::ST_IDLE;
            acc_q   <= '0;
            ext_q   <= '0;
            opnd_q  <= '0;
            addr_q  <= '0;
            op_q    <= '0;
            mod_q   <= '0;
            rep_q   <= '0;
            first_q <= 1'b0;
            cnt_q   <= '0;
            done_q  <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            acc_q   <= acc_d;
            ext_q   <= ext_d;
            opnd_q  <= opnd_d;
            addr_q  <= addr_d;
            op_q    <= op_d;
            mod_q   <= mod_d;
            rep_q   <= rep_d;
            first_q <= first_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
        end
    end

    // Outputs straight from registers
    assign rd_req  = (state_q == arith_pkg::ST_FETCH);
    assign rd_addr = addr_q;
    assign busy    = (state_q != arith_pkg::ST_IDLE);
    assign done    = done_q;
    assign acc     = acc_q;
    assign ext     = ext_q;
endmodule

// >>> core/portion_select.sv
// Word-portion selection of an operand word by the instruction modifier.
// Assumes the modifier arrives with the operand, same clock domain.
`timescale 1ns/10ps
module portion_select #(
    parameter int WIDTH = 24
) (
    input  wire logic [2:0]       modifier,
    input  wire logic [WIDTH-1:0] word_in,
    output logic      [WIDTH-1:0] word_out
);
    localparam int THIRD = WIDTH / 3;
    localparam int HALF = WIDTH / 2;

    // ========================================================================
    // Portion decode; unknown codes pass the whole word so nothing is lost
    always_comb begin
        word_out = word_in;
        unique case (modifier)
            3'd1: word_out = {{(WIDTH-THIRD){1'b0}}, word_in[THIRD-1:0]};
            3'd2: word_out = {{(WIDTH-THIRD){1'b0}},
                              word_in[2*THIRD-1:THIRD]};
            3'd3: word_out = {{(WIDTH-THIRD){1'b0}},
                              word_in[WIDTH-1:2*THIRD]};
            3'd5: word_out = {{(WIDTH-HALF){1'b0}}, word_in[HALF-1:0]};
            3'd6: word_out = {{(WIDTH-HALF){1'b0}}, word_in[WIDTH-1:HALF]};
            default: word_out = word_in;
        endcase
    end
endmodule

// >>> verification/divide_step_selective_clear_assertions.sv
// Port checker for the divide-step and selective-clear datapath.
// Assumes one clock domain; bound onto the datapath top below.
`timescale 1ns/10ps
module dssc_checker #(
    parameter int STEP_CYCLES   = 4,
    parameter int REPEAT_CYCLES = 3
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        start,
    input wire logic [23:0] instr,
    input wire logic [5:0]  repeat_count,
    input wire logic [14:0] index_value,
    input wire logic        load_en,
    input wire logic        rd_req,
    input wire logic [14:0] rd_addr,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [23:0] acc,
    input wire logic [23:0] ext
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ====================
    // Snapshot of op kind and registers at acceptance
    logic        take;
    logic [49:0] snap_q;
    logic [14:0] want_addr;
    assign take = clk_en && start && !busy;
    assign want_addr = instr[14:0] + index_value;
    always_ff @(posedge clk) begin
        if (take)
            snap_q <= {instr[23:18] == arith_pkg::OP_SEL_CLEAR,
                       repeat_count == 6'd0, acc, ext};
    end
    chk_fetch_starts: assert property (take |=> busy && rd_req)
        else $error("fetch not issued after start");
    chk_fetch_addr: assert property (take |=>
        rd_addr == $past(want_addr))
        else $error("operand address not indexed");
    chk_done_idle: assert property (
        done && $past(clk_en) |-> !busy && $past(busy))
        else $error("done without finishing a busy span");
    chk_done_pulse: assert property (done && clk_en |=> !done)
        else $error("done longer than one cycle");
    chk_busy_bound: assert property ($rose(busy) |-> ##[1:900] done)
        else $error("operation did not finish");
    chk_clear_mask: assert property (done && snap_q[49] |->
        (acc & ~snap_q[47:24]) == 24'h00_0000 && ext == snap_q[23:0])
        else $error("selective clear set a bit or touched ext");
    chk_shift_pair: assert property (
        done && !snap_q[49] && snap_q[48] |-> ext[23:1] == snap_q[22:0])
        else $error("single step did not shift ext");
    chk_idle_hold: assert property (!busy && !load_en && !take |=>
        $stable(acc) && $stable(ext))
        else $error("results moved while idle");
    chk_freeze: assert property (
        !clk_en |=> $stable(busy) && $stable(acc))
        else $error("state moved with clock enable low");
endmodule

bind divide_step_selective_clear dssc_checker #(
    .STEP_CYCLES(STEP_CYCLES), .REPEAT_CYCLES(REPEAT_CYCLES)
) dssc_checker_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .start(start),
    .instr(instr), .repeat_count(repeat_count), .index_value(index_value),
    .load_en(load_en), .rd_req(rd_req), .rd_addr(rd_addr), .busy(busy),
    .done(done), .acc(acc), .ext(ext)
);

// >>> verification/storage_model.sv
// Core storage stand-in: answers each fetch with one word after a lag.
// Assumes rd_req is registered; the lag counts every edge, fetch and take only edges with clk_en high.
`timescale 1ns/10ps
module storage_model (
    input  wire logic        clk,
    input  wire logic        clk_en,
    input  wire logic        rd_req,
    input  wire logic [23:0] word,
    input  wire logic [3:0]  lag,
    output logic             rd_valid,
    output logic      [23:0] rd_data
);
    // ====================
    // Fetch answer; data is inverted outside the strobe so stale use shows
    initial begin
        rd_valid = 1'b0;
        rd_data = 24'h00_0000;
        forever begin
            @(posedge clk);
            if (rd_req === 1'b1 && clk_en === 1'b1) begin
                repeat (lag) @(posedge clk);
                rd_valid <= 1'b1;
                rd_data <= word;
                // Hold the answer until an enabled edge has taken it
                do @(posedge clk); while (clk_en !== 1'b1);
                rd_valid <= 1'b0;
                rd_data <= ~word;
            end
        end
    end
endmodule

// >>> verification/testbench.sv
// Self-checking bench: divisions, single steps and selective clears.
// Assumes the storage model answers every fetch; short step counts.
`timescale 1ns/10ps
module testbench;
    localparam logic [5:0] DIV = arith_pkg::OP_DIVIDE_STEP;
    localparam logic [5:0] CLR = arith_pkg::OP_SEL_CLEAR;
    logic        clk, reset_n, clk_en, start, load_en, rd_req, rd_valid;
    logic        busy, done;
    logic [23:0] instr, load_acc, load_ext, rd_data, acc, ext, word, y, q;
    logic [14:0] index_value, rd_addr;
    logic [5:0]  repeat_count;
    logic [3:0]  lag;
    logic [47:0] expq[$];
    int          miscompares, checked;
    int          seed = 32'h69ec_d465;

    divide_step_selective_clear #(.STEP_CYCLES(4), .REPEAT_CYCLES(3))
    divide_step_selective_clear_inst (.clk(clk), .reset_n(reset_n),
        .clk_en(clk_en), .start(start), .instr(instr),
        .repeat_count(repeat_count), .index_value(index_value),
        .load_en(load_en), .load_acc(load_acc), .load_ext(load_ext),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .busy(busy), .done(done), .acc(acc), .ext(ext));
    storage_model storage_model_inst (.clk(clk), .clk_en(clk_en),
        .rd_req(rd_req),
        .word(word), .lag(lag), .rd_valid(rd_valid), .rd_data(rd_data));

    // ====================
    // Reference divide steps on the 48-bit pair; restore keeps old value
    function automatic logic [47:0] steps(input logic [47:0] aq,
                                          input logic [23:0] d, input int n);
        logic [23:0] a;
        for (int i = 0; i < n; i++) begin
            aq = aq << 1;
            a = aq[47:24] - d;
            if (a[23] === 1'b0) aq = {a, aq[23:1], 1'b1};
            else aq[0] = 1'b0;
        end
        return aq;
    endfunction

    // One instruction; third 1 is the low byte, third 2 the middle byte
    task automatic run(input logic [5:0] op, rep, input logic [23:0] a, b, d);
        @(negedge clk);
        {load_en, load_acc, load_ext} = {1'b1, a, b};
        @(negedge clk);
        {load_en, word, lag} = {1'b0, d, 4'($random(seed))};
        index_value = 15'($random(seed));
        instr = {op, 3'($random(seed)) | 3'd1, 15'($random(seed))};
        if (op == DIV) expq.push_back(steps({a, b}, d & 24'h00_00ff, rep + 1));
        else expq.push_back({a & ~((d >> 8) & 24'h00_00ff), b});
        {repeat_count, start} = {rep, 1'b1};
        @(negedge clk);
        start = 1'b0;
        @(negedge clk);
        clk_en = 1'b0;
        @(negedge clk);
        clk_en = 1'b1;
        for (int i = 0; i < 900 && busy !== 1'b0; i++) @(negedge clk);
    endtask

    // Each done pulse is matched with the oldest expected pair
    always @(posedge clk) begin
        if (done === 1'b1) begin
            checked++;
            if (expq.size() == 0) begin
                miscompares++;
                $display("CHECK FAILED %0t done with nothing expected",
                         $time);
            end else if ({acc, ext} !== expq.pop_front()) begin
                miscompares++;
                $display("CHECK FAILED %0t acc/ext %h %h", $time, acc, ext);
            end
        end
    end

    task report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        {reset_n, clk_en, start, load_en} = 4'b0100;
        {instr, load_acc, load_ext} = '0;
        {word, index_value, repeat_count, lag} = '0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            y = 24'($random(seed)) & 24'h00_00ff | 24'h00_0001;
            q = 24'($random(seed));
            case (i % 4)
                0: run(DIV, 6'd23, 24'h00_0000, q & 24'h7f_ffff, y);
                1: run(DIV, 6'd23, q % y, 24'($random(seed)), y);
                2: run(DIV, 6'($random(seed)) & 6'h07, q % y, q, y);
                default: run(CLR, 6'($random(seed)), q, ~q, 24'($random(seed)));
            endcase
        end
        // Let the last done pulse reach the watcher before judging
        repeat (2) @(posedge clk);
        if (expq.size() != 0) begin
            miscompares++;
            $display("CHECK FAILED %0t %0d results never seen", $time,
                     expq.size());
        end
        report_and_stop();
    end
endmodule
